// ===== core/mfc_map.svh
`ifndef MFC_MAP_SVH
`define MFC_MAP_SVH

// register byte offsets
`define MFC_CTRL_OFS 8'h00
`define MFC_REDUCTION_OFS 8'h04
`define MFC_PANEL_REF_OFS 8'h08
`define MFC_R2_MIN_OFS 8'h0c
`define MFC_R2_MAX_OFS 8'h10
`define MFC_VERIFY_SPD_OFS 8'h14
`define MFC_WIN_START_OFS 8'h18
`define MFC_WIN_END_OFS 8'h1c
`define MFC_CMP_ANGLE_OFS 8'h20
`define MFC_THRESH_OFS 8'h24
`define MFC_RELEASE_OFS 8'h28
`define MFC_STATUS_OFS 8'h2c
`define MFC_ANGLE_OFS 8'h30
`define MFC_PEAK_OFS 8'h34
`define MFC_IRQ_STATUS_OFS 8'h38
`define MFC_IRQ_CLEAR_OFS 8'h3c
`define MFC_IRQ_ENABLE_OFS 8'h40

// control register fields
`define MFC_CTRL_CHECK_EN_BIT 0
`define MFC_CTRL_SRC_LSB 1
`define MFC_SRC_R1_REF_BIT 0
`define MFC_SRC_R2_REF_BIT 1
`define MFC_SRC_R2_START_BIT 2

// reduction in hundredths, speeds in tenths of a percent, angles in degrees, threshold in percent
`define MFC_REDUCTION_MIN 16'h0001
`define MFC_REDUCTION_MAX 16'h4e20
`define MFC_REDUCTION_RST 16'h1955
`define MFC_SPEED_MIN 16'h0001
`define MFC_SPEED_MAX 16'h03e8
`define MFC_PANEL_REF_RST 16'h0320
`define MFC_R2_MIN_RST 16'h012c
`define MFC_R2_MAX_RST 16'h03e8
`define MFC_VERIFY_MAX 16'h0064
`define MFC_VERIFY_RST 16'h0064
`define MFC_ANGLE_MIN 16'h0001
`define MFC_ANGLE_MAX 16'h005a
`define MFC_WIN_START_RST 16'h001e
`define MFC_WIN_END_RST 16'h003c
`define MFC_CMP_ANGLE_RST 16'h0050
`define MFC_THRESH_MIN 16'h0001
`define MFC_THRESH_MAX 16'h001e
`define MFC_THRESH_RST 16'h0014
`define MFC_RELEASE_MAX 16'h0167
`define MFC_RELEASE_RST 16'h00b4
`define MFC_CHECK_EN_RST 1'b1
`define MFC_SRC_RST 3'h0

// mill geometry
`define MFC_DEG_PER_TURN 9'h168
`define MFC_DEG_X100_PER_TURN 32'h00008ca0
`define MFC_ZERO_TOL 9'h002
`define MFC_PCT_SCALE 32'h00000064

// interrupt bits
`define MFC_IRQ_THAWED 0
`define MFC_IRQ_FROZEN 1
`define MFC_IRQ_PARKED 2
`define MFC_IRQ_RELEASED 3
`define MFC_IRQ_W 4

`endif

// ===== core/mfc_pkg.sv
package mfc_pkg;
   typedef enum logic [2:0] {
      MFC_IDLE,
      MFC_CHECK,
      MFC_THAWED_RUN,
      MFC_RUN,
      MFC_REVERSE,
      MFC_PARKED
   } mfc_state_t;
endpackage

// ===== core/mfc_angle.sv
`timescale 1ns/1ps
`include "mfc_map.svh"

// turns motor encoder steps into whole mill degrees, modulo one turn
module mfc_angle #(
   parameter int PULSES_PER_REV = 1024
)(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic motor_step,
   input wire logic motor_step_rev,
   input wire logic [15:0] reduction,
   output logic [8:0] mill_angle
);
   logic [31:0] modulus;
   logic [31:0] frac;

   // one mill turn is pulses_per_rev * reduction / 100 motor steps; frac holds the part degree in units of 1/modulus
   assign modulus = 32'(PULSES_PER_REV) * {16'h0000, reduction};

   // one degree step per pulse at most, so this holds while modulus exceeds 36000
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         frac <= 32'h0;
         mill_angle <= 9'h0;
      end
      else if (motor_step && !motor_step_rev)
      begin
         if (frac + `MFC_DEG_X100_PER_TURN >= modulus) // [R16]
         begin
            frac <= frac + `MFC_DEG_X100_PER_TURN - modulus;
            mill_angle <= (mill_angle == `MFC_DEG_PER_TURN - 9'h1) ? 9'h0 : mill_angle + 9'h1;
         end
         else
            frac <= frac + `MFC_DEG_X100_PER_TURN;
      end
      else if (motor_step && motor_step_rev)
      begin
         if (frac >= `MFC_DEG_X100_PER_TURN)
            frac <= frac - `MFC_DEG_X100_PER_TURN;
         else
         begin
            frac <= frac + modulus - `MFC_DEG_X100_PER_TURN; // [R16]
            mill_angle <= (mill_angle == 9'h0) ? `MFC_DEG_PER_TURN - 9'h1 : mill_angle - 9'h1;
         end
      end
   end
endmodule // mfc_angle

// ===== core/mfc_start_seq.sv
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "mfc_map.svh"

// What this block does
// [R01] Start the mill only when ready and a start command arrives.
// [R02] Overall reduction settable 0.01 to 200.00, default 64.85.
// [R03] Panel reference 0.1 to 100.0 percent, default 80.0, used in remote one.
// [R04] Selector bits pick remote-one reference, remote-two reference, remote-two start source.
// [R05] Remote-two reference clamped between minimum 30.0 and maximum 100.0 percent.
// [R06] With checking on, start runs at verification speed and holds it.
// [R07] Verification speed settable 0.1 to 10.0 percent, default 10.0.
// [R08] Track peak torque inside window 30 to 60 degrees, settable 1 to 90.
// [R09] At compare angle, peak minus present torque above threshold means thawed.
// [R10] Thawed: keep turning to release angle, then take operating reference.
// [R11] Frozen: reverse the motor and stop near zero degrees.
// [R12] Check enable bit defaults to one; zero disables the check.
// [R13] Compare angle settable 1 to 90 degrees, default 80.
// [R14] Torque reduction threshold settable 1 to 30 percent, default 20.
// [R15] Release angle settable 1 to 359 degrees, default 180.
// [R16] Mill angle is motor rotation over reduction, modulo 360 degrees.
module mfc_start_seq #(
   parameter int PULSES_PER_REV = 1024
)(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic drive_ready,
   input wire logic remote_mode_two,
   input wire logic start_panel,
   input wire logic start_fieldbus,
   input wire logic start_digital,
   input wire logic [15:0] analog_ref,
   input wire logic [15:0] fieldbus_ref,
   input wire logic [15:0] motor_torque,
   input wire logic motor_step,
   input wire logic motor_step_rev,
   output logic [15:0] speed_cmd,
   output logic run_fwd,
   output logic run_rev,
   output logic [8:0] mill_angle,
   output logic irq
);
   logic check_en;
   logic [2:0] src_sel;
   logic [15:0] reduction;
   logic [15:0] panel_ref;
   logic [15:0] r2_min;
   logic [15:0] r2_max;
   logic [15:0] verify_spd;
   logic [15:0] win_start;
   logic [15:0] win_end;
   logic [15:0] cmp_angle;
   logic [15:0] thresh;
   logic [15:0] release_angle;
   logic [`MFC_IRQ_W-1:0] irq_status;
   logic [`MFC_IRQ_W-1:0] irq_enable;
   logic [`MFC_IRQ_W-1:0] irq_event;
   logic [`MFC_IRQ_W-1:0] irq_clear;
   logic frozen_load_check_done;
   logic load_frozen;
   logic [15:0] peak_torque;
   logic start_req;
   logic start_req_d;
   logic [15:0] op_ref;
   logic [15:0] next_r2_ref;
   logic [31:0] torque_drop;
   logic [15:0] wdata16;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic [31:0] next_prdata;
   mfc_pkg::mfc_state_t state;

   // clamp a written setting into its legal range
   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      begin
         clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction

   // zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wdata16 = pwdata[15:0];
   assign wr_en = psel && penable && pwrite && mapped;
   assign rd_en = psel && !penable && !pwrite;
   assign pslverr = psel && penable && !mapped;
   assign irq_clear = (psel && penable && pwrite && paddr == `MFC_IRQ_CLEAR_OFS) ? pwdata[`MFC_IRQ_W-1:0] : '0;

   // address decode; status and clear are one-way registers
   always_comb
   begin
      mapped = 1'b1;
      if (paddr[1:0] != 2'b00)
         mapped = 1'b0;
      else if (paddr == `MFC_IRQ_CLEAR_OFS)
         mapped = pwrite;
      else if (paddr == `MFC_STATUS_OFS || paddr == `MFC_ANGLE_OFS || paddr == `MFC_PEAK_OFS
               || paddr == `MFC_IRQ_STATUS_OFS)
         mapped = !pwrite;
      else if (paddr > `MFC_IRQ_ENABLE_OFS)
         mapped = 1'b0;
   end

   // settings registers, written values clamped to their documented ranges
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         check_en <= `MFC_CHECK_EN_RST; // [R12]
         src_sel <= `MFC_SRC_RST;
         reduction <= `MFC_REDUCTION_RST;
         panel_ref <= `MFC_PANEL_REF_RST;
         r2_min <= `MFC_R2_MIN_RST;
         r2_max <= `MFC_R2_MAX_RST;
         verify_spd <= `MFC_VERIFY_RST;
         win_start <= `MFC_WIN_START_RST;
         win_end <= `MFC_WIN_END_RST;
         cmp_angle <= `MFC_CMP_ANGLE_RST;
         thresh <= `MFC_THRESH_RST;
         release_angle <= `MFC_RELEASE_RST;
         irq_enable <= '0;
      end
      else if (wr_en)
      begin
         if (paddr == `MFC_CTRL_OFS)
         begin
            check_en <= pwdata[`MFC_CTRL_CHECK_EN_BIT]; // [R12]
            src_sel <= pwdata[`MFC_CTRL_SRC_LSB +: 3]; // [R04]
         end
         else if (paddr == `MFC_REDUCTION_OFS)
            reduction <= clamp(wdata16, `MFC_REDUCTION_MIN, `MFC_REDUCTION_MAX); // [R02]
         else if (paddr == `MFC_PANEL_REF_OFS)
            panel_ref <= clamp(wdata16, `MFC_SPEED_MIN, `MFC_SPEED_MAX); // [R03]
         else if (paddr == `MFC_R2_MIN_OFS)
            r2_min <= clamp(wdata16, `MFC_SPEED_MIN, `MFC_SPEED_MAX); // [R05]
         else if (paddr == `MFC_R2_MAX_OFS)
            r2_max <= clamp(wdata16, `MFC_SPEED_MIN, `MFC_SPEED_MAX); // [R05]
         else if (paddr == `MFC_VERIFY_SPD_OFS)
            verify_spd <= clamp(wdata16, `MFC_SPEED_MIN, `MFC_VERIFY_MAX); // [R07]
         else if (paddr == `MFC_WIN_START_OFS)
            win_start <= clamp(wdata16, `MFC_ANGLE_MIN, `MFC_ANGLE_MAX); // [R08]
         else if (paddr == `MFC_WIN_END_OFS)
            win_end <= clamp(wdata16, `MFC_ANGLE_MIN, `MFC_ANGLE_MAX); // [R08]
         else if (paddr == `MFC_CMP_ANGLE_OFS)
            cmp_angle <= clamp(wdata16, `MFC_ANGLE_MIN, `MFC_ANGLE_MAX); // [R13]
         else if (paddr == `MFC_THRESH_OFS)
            thresh <= clamp(wdata16, `MFC_THRESH_MIN, `MFC_THRESH_MAX); // [R14]
         else if (paddr == `MFC_RELEASE_OFS)
            release_angle <= clamp(wdata16, `MFC_ANGLE_MIN, `MFC_RELEASE_MAX); // [R15]
         else if (paddr == `MFC_IRQ_ENABLE_OFS)
            irq_enable <= pwdata[`MFC_IRQ_W-1:0];
      end
   end

   // read mux, latched in the setup cycle so prdata is a flop in the access cycle
   always_comb
   begin
      next_prdata = 32'h0;
      if (paddr == `MFC_CTRL_OFS)
         next_prdata = {28'h0, src_sel, check_en};
      else if (paddr == `MFC_REDUCTION_OFS)
         next_prdata = {16'h0, reduction};
      else if (paddr == `MFC_PANEL_REF_OFS)
         next_prdata = {16'h0, panel_ref};
      else if (paddr == `MFC_R2_MIN_OFS)
         next_prdata = {16'h0, r2_min};
      else if (paddr == `MFC_R2_MAX_OFS)
         next_prdata = {16'h0, r2_max};
      else if (paddr == `MFC_VERIFY_SPD_OFS)
         next_prdata = {16'h0, verify_spd};
      else if (paddr == `MFC_WIN_START_OFS)
         next_prdata = {16'h0, win_start};
      else if (paddr == `MFC_WIN_END_OFS)
         next_prdata = {16'h0, win_end};
      else if (paddr == `MFC_CMP_ANGLE_OFS)
         next_prdata = {16'h0, cmp_angle};
      else if (paddr == `MFC_THRESH_OFS)
         next_prdata = {16'h0, thresh};
      else if (paddr == `MFC_RELEASE_OFS)
         next_prdata = {16'h0, release_angle};
      else if (paddr == `MFC_STATUS_OFS)
         next_prdata = {26'h0, load_frozen, frozen_load_check_done, 1'b0, state};
      else if (paddr == `MFC_ANGLE_OFS)
         next_prdata = {23'h0, mill_angle};
      else if (paddr == `MFC_PEAK_OFS)
         next_prdata = {16'h0, peak_torque};
      else if (paddr == `MFC_IRQ_STATUS_OFS)
         next_prdata = {28'h0, irq_status};
      else if (paddr == `MFC_IRQ_ENABLE_OFS)
         next_prdata = {28'h0, irq_enable};
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         prdata <= 32'h0;
      else if (rd_en)
         prdata <= next_prdata;
   end

   // sticky events; a new event in the clearing cycle survives the clear
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         irq_status <= '0;
      else
         irq_status <= (irq_status & ~irq_clear) | irq_event;
   end

   assign irq = |(irq_status & irq_enable);

   // mill angle from motor steps and the reduction setting
   mfc_angle #(
      .PULSES_PER_REV(PULSES_PER_REV)
   ) u_angle (
      .clock(clock),
      .reset_n(reset_n),
      .motor_step(motor_step),
      .motor_step_rev(motor_step_rev),
      .reduction(reduction),
      .mill_angle(mill_angle)
   );

   // start source: remote two may take its start from fieldbus or a digital input
   always_comb
   begin
      if (!remote_mode_two)
         start_req = start_panel;
      else if (src_sel[`MFC_SRC_R2_START_BIT]) // [R04]
         start_req = start_digital;
      else
         start_req = start_fieldbus;
   end

   // operating reference per mode; remote two clamped to its limits
   always_comb
   begin
      next_r2_ref = src_sel[`MFC_SRC_R2_REF_BIT] ? analog_ref : fieldbus_ref; // [R04]
      if (next_r2_ref < r2_min)
         next_r2_ref = r2_min; // [R05]
      else if (next_r2_ref > r2_max)
         next_r2_ref = r2_max; // [R05]
      if (remote_mode_two)
         op_ref = next_r2_ref;
      else
         op_ref = src_sel[`MFC_SRC_R1_REF_BIT] ? analog_ref : panel_ref; // [R03] [R04]
   end

   // drop against peak, both scaled so the threshold reads as a percentage of the peak
   assign torque_drop = (motor_torque < peak_torque) ? 32'(peak_torque - motor_torque) : 32'h0;

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         start_req_d <= 1'b0;
      else
         start_req_d <= start_req;
   end

   // start sequencer; dropping the start request stops the mill from any state
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         state <= mfc_pkg::MFC_IDLE;
         peak_torque <= 16'h0;
         frozen_load_check_done <= 1'b0;
         load_frozen <= 1'b0;
         irq_event <= '0;
      end
      else
      begin
         irq_event <= '0;
         if (!start_req && state != mfc_pkg::MFC_IDLE)
            state <= mfc_pkg::MFC_IDLE;
         else
         begin
            case (state)
               mfc_pkg::MFC_IDLE:
               begin
                  // edge of start only, so a held start cannot restart a parked mill
                  if (drive_ready && start_req && !start_req_d) // [R01]
                  begin
                     peak_torque <= 16'h0;
                     frozen_load_check_done <= 1'b0;
                     load_frozen <= 1'b0;
                     state <= check_en ? mfc_pkg::MFC_CHECK : mfc_pkg::MFC_RUN; // [R06] [R12]
                  end
               end
               mfc_pkg::MFC_CHECK:
               begin
                  if ({7'h0, mill_angle} >= win_start && {7'h0, mill_angle} <= win_end
                      && motor_torque > peak_torque)
                     peak_torque <= motor_torque; // [R08]
                  if ({7'h0, mill_angle} == cmp_angle)
                  begin
                     frozen_load_check_done <= 1'b1;
                     if (torque_drop * `MFC_PCT_SCALE > {16'h0, peak_torque} * {16'h0, thresh}) // [R09]
                     begin
                        irq_event[`MFC_IRQ_THAWED] <= 1'b1;
                        state <= mfc_pkg::MFC_THAWED_RUN;
                     end
                     else
                     begin
                        load_frozen <= 1'b1;
                        irq_event[`MFC_IRQ_FROZEN] <= 1'b1;
                        state <= mfc_pkg::MFC_REVERSE; // [R11]
                     end
                  end
               end
               mfc_pkg::MFC_THAWED_RUN:
               begin
                  if ({7'h0, mill_angle} >= release_angle) // [R10]
                  begin
                     irq_event[`MFC_IRQ_RELEASED] <= 1'b1;
                     state <= mfc_pkg::MFC_RUN;
                  end
               end
               mfc_pkg::MFC_REVERSE:
               begin
                  if (mill_angle <= `MFC_ZERO_TOL) // [R11]
                  begin
                     irq_event[`MFC_IRQ_PARKED] <= 1'b1;
                     state <= mfc_pkg::MFC_PARKED;
                  end
               end
               mfc_pkg::MFC_RUN:
               begin
               end
               mfc_pkg::MFC_PARKED:
               begin
               end
               default:
                  state <= mfc_pkg::MFC_IDLE;
            endcase
         end
      end
   end

   // motor commands follow the state; verification speed holds through check and reversal
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         speed_cmd <= 16'h0;
         run_fwd <= 1'b0;
         run_rev <= 1'b0;
      end
      else
      begin
         run_fwd <= state == mfc_pkg::MFC_CHECK || state == mfc_pkg::MFC_THAWED_RUN
                    || state == mfc_pkg::MFC_RUN; // [R01]
         run_rev <= state == mfc_pkg::MFC_REVERSE; // [R11]
         if (state == mfc_pkg::MFC_RUN)
            speed_cmd <= op_ref; // [R10]
         else if (state == mfc_pkg::MFC_CHECK || state == mfc_pkg::MFC_THAWED_RUN
                  || state == mfc_pkg::MFC_REVERSE)
            speed_cmd <= verify_spd; // [R06]
         else
            speed_cmd <= 16'h0;
      end
   end
endmodule // mfc_start_seq

// ===== dv/mfc_motor_model.sv
`timescale 1ns/1ps

// motor and gearbox stand-in: steps the encoder while a direction is commanded
module mfc_motor_model (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic run_fwd,
   input wire logic run_rev,
   input wire logic [15:0] speed_cmd,
   input wire logic [8:0] mill_angle,
   input wire logic frozen,
   output logic motor_step,
   output logic motor_step_rev,
   output logic [15:0] motor_torque
);
   logic [1:0] pace;

   // one step every fourth cycle, so the angle tracker never sees two steps back to back
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         pace <= 2'h0;
         motor_step <= 1'b0;
         motor_step_rev <= 1'b0;
      end
      else
      begin
         pace <= pace + 2'h1;
         motor_step <= (run_fwd ^ run_rev) && (speed_cmd != 16'h0000) && (pace == 2'h3);
         motor_step_rev <= run_rev;
      end
   end

   // breakaway torque below the window; a loose charge slumps past it, a frozen one does not
   always_comb
   begin
      if (mill_angle < 9'h01e)
         motor_torque = 16'h05dc;
      else if (frozen || mill_angle <= 9'h03c)
         motor_torque = 16'h03e8;
      else
         motor_torque = 16'h0190;
   end
endmodule // mfc_motor_model

// ===== dv/mfc_start_seq_monitor.sv
`timescale 1ns/1ps

// watches direction, angle and bus timing at the sequencer pins
module mfc_start_seq_monitor (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic drive_ready,
   input wire logic motor_step,
   input wire logic motor_step_rev,
   input wire logic [15:0] speed_cmd,
   input wire logic run_fwd,
   input wire logic run_rev,
   input wire logic [8:0] mill_angle
);
   default clocking mon_clk @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   // start edge sits two or three samples before the run level appears
   a_start_when_ready: assert property ($rose(run_fwd) |-> $past(drive_ready, 2) || $past(drive_ready, 3))
      else $error("run began while drive not ready");
   a_one_direction: assert property (!(run_fwd && run_rev))
      else $error("both directions commanded");
   a_reverse_slow: assert property (run_rev |-> speed_cmd != 16'h0000 && speed_cmd <= 16'h0064)
      else $error("reverse speed outside verification range");
   a_angle_holds: assert property (!motor_step |=> $stable(mill_angle))
      else $error("angle moved without a step");
   a_angle_fwd: assert property (motor_step && !motor_step_rev |=> mill_angle == $past(mill_angle)
      || mill_angle == (($past(mill_angle) == 9'h167) ? 9'h000 : $past(mill_angle) + 9'h001))
      else $error("forward step moved the angle wrongly");
   a_angle_back: assert property (motor_step && motor_step_rev |=> mill_angle == $past(mill_angle)
      || mill_angle == (($past(mill_angle) == 9'h000) ? 9'h167 : $past(mill_angle) - 9'h001))
      else $error("reverse step moved the angle wrongly");
   a_angle_wraps: assert property (mill_angle <= 9'h167)
      else $error("angle beyond one turn");
   a_park_near_zero: assert property ($fell(run_rev) |-> mill_angle <= 9'h002)
      else $error("reverse ended away from zero");
   // a speed change while already turning forward is only the release to operating speed
   a_release_late: assert property (run_fwd && $past(run_fwd) && speed_cmd != $past(speed_cmd)
      |-> mill_angle >= 9'h0b4)
      else $error("operating speed before release angle");
   a_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("error flag outside access cycle");
   a_zero_wait: assert property (psel && penable |-> pready)
      else $error("access cycle without ready");
endmodule // mfc_start_seq_monitor

bind mfc_start_seq mfc_start_seq_monitor u_mon (.clock, .reset_n, .psel, .penable, .pready, .pslverr, .drive_ready,
   .motor_step, .motor_step_rev, .speed_cmd, .run_fwd, .run_rev, .mill_angle);

// ===== dv/tb.sv
`timescale 1ns/1ps

module tb;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic drive_ready = 1'b1, remote_mode_two = 1'b0, frozen = 1'b0;
   logic start_panel = 1'b0, start_fieldbus = 1'b0, start_digital = 1'b0;
   logic [15:0] analog_ref = 16'h0032, fieldbus_ref = 16'h05dc, motor_torque, speed_cmd;
   logic motor_step, motor_step_rev, run_fwd, run_rev, irq;
   logic [8:0] mill_angle;
   int num_errors = 0, total_checks = 0, cycles = 0, net_steps = 0;
   logic [7:0] reg_addr [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};
   logic [31:0] reg_rst [11] = '{32'h1, 32'h1955, 32'h320, 32'h12c, 32'h3e8, 32'h64, 32'h1e, 32'h3c, 32'h50,
      32'h14, 32'hb4};
   logic [7:0] clamp_addr [6] = '{8'h14, 8'h24, 8'h28, 8'h20, 8'h04, 8'h0c};
   logic [31:0] clamp_in [6] = '{32'hc8, 32'h0, 32'h190, 32'h5b, 32'h7530, 32'h0};
   logic [31:0] clamp_out [6] = '{32'h64, 32'h1, 32'h167, 32'h5a, 32'h4e20, 32'h1};

   // small encoder count keeps a mill turn near two thousand cycles
   mfc_start_seq #(.PULSES_PER_REV(8)) u_dut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .drive_ready, .remote_mode_two, .start_panel, .start_fieldbus, .start_digital,
      .analog_ref, .fieldbus_ref, .motor_torque, .motor_step, .motor_step_rev, .speed_cmd, .run_fwd, .run_rev,
      .mill_angle, .irq);
   mfc_motor_model u_motor (.clock, .reset_n, .run_fwd, .run_rev, .speed_cmd, .mill_angle, .frozen,
      .motor_step, .motor_step_rev, .motor_torque);

   always #2.5 clock = ~clock;

   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // net step count gives the expected angle; cycle ceiling cuts a hang short
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (!reset_n)
         net_steps <= 0;
      else if (motor_step === 1'b1)
         net_steps <= net_steps + (motor_step_rev ? -1 : 1);
      if (cycles == 30000)
      begin
         num_errors++;
         finish_test();
      end
   end

   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      apb(1'b0, a, 32'h0);
      cmp(name, exp, rdata);
   endtask

   // run with the check off from the selected start source, then stop
   task automatic plain(input logic [31:0] ctrl, input logic r2, input logic [2:0] src, input logic [15:0] exp);
      apb(1'b1, 8'h00, ctrl);
      remote_mode_two <= r2;
      @(posedge clock);
      {start_digital, start_fieldbus, start_panel} <= src;
      wait (run_fwd === 1'b1);
      @(posedge clock);
      cmp("operating speed", 32'(exp), 32'(speed_cmd));
      {start_digital, start_fieldbus, start_panel} <= 3'b000;
      wait (run_fwd === 1'b0);
      @(posedge clock);
   endtask

   initial
   begin
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      for (int i = 0; i < 11; i++) rd(reg_addr[i], reg_rst[i], "reset value");
      rd(8'h40, 32'h0, "irq enable reset");
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, clamp_addr[i], clamp_in[i]);
         rd(clamp_addr[i], clamp_out[i], "clamped setting");
      end
      for (int i = 1; i < 11; i++) apb(1'b1, reg_addr[i], reg_rst[i]);
      apb(1'b0, 8'h44, 32'h0);
      cmp("unmapped error", 32'h1, 32'(err));
      apb(1'b1, 8'h30, 32'h0);
      cmp("read-only error", 32'h1, 32'(err));
      apb(1'b1, 8'h40, 32'hf);
      // start while not ready, then ready with start merely held: both ignored
      @(posedge clock);
      drive_ready <= 1'b0;
      start_panel <= 1'b1;
      repeat (10) @(posedge clock);
      drive_ready <= 1'b1;
      repeat (10) @(posedge clock);
      cmp("run while not ready", 32'h0, 32'(run_fwd));
      start_panel <= 1'b0;
      repeat (3) @(posedge clock);
      // loose charge: verify speed, verdict, release to panel reference
      start_panel <= 1'b1;
      wait (run_fwd === 1'b1);
      @(posedge clock);
      cmp("verify speed", 32'h64, 32'(speed_cmd));
      wait (speed_cmd === 16'h0320);
      @(posedge clock);
      cmp("release angle", 32'h1, 32'(mill_angle >= 9'h0b4));
      rd(8'h38, 32'h9, "irq status thawed");
      rd(8'h34, 32'h3e8, "peak torque");
      rd(8'h2c, 32'h13, "status run");
      cmp("irq raised", 32'h1, 32'(irq));
      // the write lands on the sampling edge itself, so irq is only settled one edge later
      apb(1'b1, 8'h40, 32'h0);
      @(posedge clock);
      cmp("irq masked", 32'h0, 32'(irq));
      apb(1'b1, 8'h40, 32'hf);
      apb(1'b1, 8'h3c, 32'hf);
      @(posedge clock);
      cmp("irq cleared", 32'h0, 32'(irq));
      start_panel <= 1'b0;
      wait (run_fwd === 1'b0);
      plain(32'h2, 1'b0, 3'b001, 16'h0032);
      plain(32'hc, 1'b1, 3'b100, 16'h012c);
      plain(32'h8, 1'b1, 3'b100, 16'h03e8);
      plain(32'h4, 1'b1, 3'b010, 16'h012c);
      repeat (8) @(posedge clock);
      cmp("mill angle", 32'((net_steps * 36000 / 51880) % 360), 32'(mill_angle));
      // frozen charge: reverse and park near zero
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h3c, 32'hf);
      remote_mode_two <= 1'b0;
      frozen <= 1'b1;
      start_panel <= 1'b1;
      wait (run_rev === 1'b1);
      wait (run_rev === 1'b0);
      @(posedge clock);
      rd(8'h2c, 32'h35, "status parked");
      rd(8'h38, 32'h6, "irq status frozen");
      cmp("parked near zero", 32'h1, 32'(mill_angle <= 9'h002));
      start_panel <= 1'b0;
      finish_test();
   end
endmodule // tb
